// ==== pcrb_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the panel control register bank.
`ifndef PCRB_CFG_SVH
`define PCRB_CFG_SVH
`define PCRB_PORT_INDEX 16'h03d4
`define PCRB_PORT_DATA 16'h03d5
`define PCRB_IDX_IFSEL 8'ha1
`define PCRB_IDX_ENH 8'ha2
`define PCRB_IDX_EXP 8'ha3
`define PCRB_IDX_ACMOD 8'ha4
`define PCRB_IDX_RES 8'ha5
`define PCRB_IDX_RSV6 8'ha6
`define PCRB_IDX_RSV7 8'ha7
`define PCRB_IDX_FIRST 8'ha1
`define PCRB_NUM_REGS 7
`define PCRB_REG_RESET 8'h00
`define PCRB_IDX_RESET 8'h00
`define PCRB_IF_STN8 0
`define PCRB_IF_ESTN 1
`define PCRB_IF_CRTLIKE 2
`define PCRB_IF_CRTDIS 3
`define PCRB_IF_FPEN 4
`define PCRB_IF_PL8 5
`define PCRB_IF_GRAY 6
`define PCRB_IF_TV 7
`define PCRB_EN_INVTXT 0
`define PCRB_EN_INVGFX 1
`define PCRB_EN_BLINK_LO 2
`define PCRB_EN_MAXCON 4
`define PCRB_EN_ATTR 5
`define PCRB_EN_RGBI 6
`define PCRB_EN_FULLCUR 7
`define PCRB_EX_VTXT 0
`define PCRB_EX_VGFX 1
`define PCRB_EX_DOT8 2
`define PCRB_EX_SHMONO 3
`define PCRB_EX_SHCOL 4
`define PCRB_EX_EXTFB 5
`define PCRB_EX_X244 6
`define PCRB_EX_X242 7
`define PCRB_RS_800 0
`define PCRB_RS_600 1
`define PCRB_RS_HTXT 2
`define PCRB_RS_HGFX 3
`define PCRB_RS_EQ 4
`define PCRB_BLINK_16 8'h0f
`define PCRB_BLINK_32 8'h1f
`define PCRB_BLINK_64 8'h3f
`define PCRB_BLINK_128 8'h7f
`define PCRB_GRAY_MAX 4'hf
`define PCRB_GRAY_MIN 4'h0
`endif

// ==== pcrb_pkg.sv ====
// Types shared by the panel control register bank.
package pcrb_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pcrb_io_t;
  typedef struct packed {
    logic stn8;
    logic enh_stn;
    logic crt_like_sync;
    logic crt_en;
    logic fp_en;
    logic plasma8;
    logic gray_conv;
    logic tv_en;
    logic tv_eq;
    logic shadow_mono;
    logic shadow_color;
    logic ext_fb;
    logic pseudo_fb;
    logic dot8;
    logic full_cursor;
    logic panel_800;
    logic grp_600;
    logic [1:0] extra_lines;
  } pcrb_mode_t;
  typedef enum logic [1:0] {
    PCRB_PT_MONO_DS = 2'b00,
    PCRB_PT_COLOR_DS = 2'b01,
    PCRB_PT_OTHER = 2'b11
  } pcrb_ptype_t;
endpackage : pcrb_pkg

// ==== pcrb_regfile.sv ====
// Seven-entry register memory with registered read data.
`timescale 1ns/1ns
`include "pcrb_cfg.svh"
module pcrb_regfile
  import pcrb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [2:0] raddr_i,
  output logic [7:0] rdata_o,
  output logic [`PCRB_NUM_REGS*8-1:0] flat_o
);
  typedef struct packed {
    logic [`PCRB_NUM_REGS-1:0][7:0] mem;
    logic [7:0] rd;
  } pcrb_rf_t;
  pcrb_rf_t st_ff;
  pcrb_rf_t nxt_st;

  // Write updates one entry; read data is registered.
  always_comb
  begin
    nxt_st = st_ff;
    if (we_i && (waddr_i < 3'(`PCRB_NUM_REGS)))
    begin
      nxt_st.mem[waddr_i] = wdata_i;
    end
    nxt_st.rd = (raddr_i < 3'(`PCRB_NUM_REGS)) ? st_ff.mem[raddr_i] : 8'h00;
  end

  // All entries clear to zero on reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0; // RULE22
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rd;
  assign flat_o = st_ff.mem;
endmodule : pcrb_regfile

// ==== pcrb_bank.sv ====
// Panel control register bank behind an index and data port pair.
`timescale 1ns/1ns
`include "pcrb_cfg.svh"
// Notes on behaviour
// RULE1: Bit 0 selects 8-bit color STN.
// RULE2: Bit 1 selects enhanced STN timing.
// RULE3: Bit 2 makes TFT pulses CRT-like syncs.
// RULE4: Bit 3 disables CRT; bit 4 enables panel.
// RULE5: Bit 5 picks 8-bit or 4-bit plasma.
// RULE6: Bit 6 enables mono gray conversion.
// RULE7: Bit 7 enables TV, composite sync out.
// RULE8: Invert panel pixels in text/graphics.
// RULE9: Blink field picks 1/16 to 1/128.
// RULE10: Maximum contrast forces gray extremes.
// RULE11: Emulation derives gray from RGBI bits.
// RULE12: Full cursor ignores programmed shape.
// RULE13: Vertical and horizontal expansion bits.
// RULE14: Force eight-dot character cells.
// RULE15: Shadow buffers only in dual-scan modes.
// RULE16: External or pseudo frame buffer choice.
// RULE17: Extra line clock per frame bits.
// RULE18: Modulation toggles after count, else frame.
// RULE19: Panel width 640 or 800.
// RULE20: Vertical group 480 or 600 select.
// RULE21: Equalizing pulses in composite sync.
// RULE22: All registers read/write, reset zero.
// RULE23: Software writes index, then data.
module pcrb_bank
  import pcrb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pcrb_pkg::pcrb_io_t io_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire pcrb_pkg::pcrb_ptype_t ptype_i,
  input wire logic text_mode_i,
  input wire logic gfx16_i,
  input wire logic ext_vtim_i,
  input wire logic [1:0] misc_out_hi_i,
  input wire logic [7:0] pix_i,
  input wire logic [3:0] attr_rgbi_i,
  input wire logic [3:0] fg_gray_i,
  input wire logic [3:0] bg_gray_i,
  input wire logic line_pulse_i,
  input wire logic frame_marker_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic csync_i,
  input wire logic csync_eq_i,
  output pcrb_pkg::pcrb_mode_t mode_o,
  output logic [7:0] pix_o,
  output logic [3:0] fg_gray_o,
  output logic [3:0] bg_gray_o,
  output logic [3:0] emu_gray_o,
  output logic emu_gray_en_o,
  output logic [7:0] blink_mask_o,
  output logic vexp_o,
  output logic hexp_o,
  output logic use_600_grp_o,
  output logic line_pulse_o,
  output logic frame_marker_o,
  output logic hsync_o,
  output logic ac_modulation_output_o
);
  import pcrb_pkg::*;

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] ac_cnt;
    logic ac_phase;
    logic rvalid;
    logic [7:0] pix;
    logic [3:0] fg;
    logic [3:0] bg;
    logic [3:0] emu;
    logic emu_en;
    logic [7:0] blink;
    logic lp;
    logic fm;
    logic hs;
    logic fm_prev;
  } pcrb_st_t;
  pcrb_st_t st_ff;
  pcrb_st_t nxt_st;
  logic [`PCRB_NUM_REGS*8-1:0] regs;
  logic [7:0] r_if;
  logic [7:0] r_en;
  logic [7:0] r_ex;
  logic [7:0] r_ac;
  logic [7:0] r_rs;
  logic data_wr;
  logic data_rd;
  logic [2:0] slot;

  // Maps an index to a slot in the bank; out of range gives seven.
  function automatic logic [2:0] pcrb_slot(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - `PCRB_IDX_FIRST;
    if ((idx >= `PCRB_IDX_IFSEL) && (idx <= `PCRB_IDX_RSV7))
    begin
      pcrb_slot = off[2:0];
    end
    else
    begin
      pcrb_slot = 3'h7;
    end
  endfunction : pcrb_slot

  // Data port strobes use the held index.
  assign data_wr = io_i.wr && (io_i.addr == `PCRB_PORT_DATA); // RULE23
  assign data_rd = io_i.rd && (io_i.addr == `PCRB_PORT_DATA);
  assign slot = pcrb_slot(st_ff.index);

  pcrb_regfile u_rf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(data_wr),
    .waddr_i(slot),
    .wdata_i(io_i.wdata),
    .raddr_i(slot),
    .rdata_o(rdata_o),
    .flat_o(regs)
  );

  // Unpack the working registers.
  assign r_if = regs[7:0];
  assign r_en = regs[15:8];
  assign r_ex = regs[23:16];
  assign r_ac = regs[31:24];
  assign r_rs = regs[39:32];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Static mode outputs from the register bits, some gated by panel type or text mode.
  always_comb
  begin
    mode_o = '0;
    mode_o.stn8 = r_if[`PCRB_IF_STN8]; // RULE1
    mode_o.enh_stn = r_if[`PCRB_IF_ESTN]; // RULE2
    mode_o.crt_like_sync = r_if[`PCRB_IF_CRTLIKE]; // RULE3
    mode_o.crt_en = ~r_if[`PCRB_IF_CRTDIS]; // RULE4
    mode_o.fp_en = r_if[`PCRB_IF_FPEN]; // RULE4
    mode_o.plasma8 = r_if[`PCRB_IF_PL8]; // RULE5
    mode_o.gray_conv = r_if[`PCRB_IF_GRAY]; // RULE6
    mode_o.tv_en = r_if[`PCRB_IF_TV]; // RULE7
    mode_o.tv_eq = r_rs[`PCRB_RS_EQ]; // RULE21
    mode_o.shadow_mono = r_ex[`PCRB_EX_SHMONO] && (ptype_i == PCRB_PT_MONO_DS); // RULE15
    mode_o.shadow_color = r_ex[`PCRB_EX_SHCOL] && (ptype_i == PCRB_PT_COLOR_DS); // RULE15
    mode_o.ext_fb = r_ex[`PCRB_EX_EXTFB] && (ptype_i == PCRB_PT_COLOR_DS); // RULE16
    mode_o.pseudo_fb = ~r_ex[`PCRB_EX_EXTFB] && (ptype_i == PCRB_PT_COLOR_DS); // RULE16
    mode_o.dot8 = r_ex[`PCRB_EX_DOT8]; // RULE14
    mode_o.full_cursor = r_en[`PCRB_EN_FULLCUR] && text_mode_i; // RULE12
    mode_o.panel_800 = r_rs[`PCRB_RS_800]; // RULE19
    mode_o.grp_600 = r_rs[`PCRB_RS_600];
    mode_o.extra_lines = {1'b0, r_ex[`PCRB_EX_X244]} + {1'b0, r_ex[`PCRB_EX_X242]}; // RULE17
  end

  // Expansion and group selection per display mode.
  assign vexp_o = text_mode_i ? r_ex[`PCRB_EX_VTXT] : r_ex[`PCRB_EX_VGFX]; // RULE13
  assign hexp_o = text_mode_i ? r_rs[`PCRB_RS_HTXT] : r_rs[`PCRB_RS_HGFX]; // RULE13
  assign use_600_grp_o = ext_vtim_i && (misc_out_hi_i == 2'b11) && r_rs[`PCRB_RS_600]; // RULE20

  // ----------------------------------------------------------------
  // Datapath and modulation
  // ----------------------------------------------------------------
  // Next-state logic: index port, pixel shaping, syncs and modulation.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rvalid = data_rd;
    if (io_i.wr && (io_i.addr == `PCRB_PORT_INDEX))
    begin
      nxt_st.index = io_i.wdata;
    end
    // Pixel inversion per mode.
    if ((text_mode_i && r_en[`PCRB_EN_INVTXT]) || (!text_mode_i && r_en[`PCRB_EN_INVGFX]))
    begin
      nxt_st.pix = ~pix_i; // RULE8
    end
    else
    begin
      nxt_st.pix = pix_i;
    end
    // Blink divider mask.
    case (r_en[`PCRB_EN_BLINK_LO +: 2])
      2'b00: nxt_st.blink = `PCRB_BLINK_16; // RULE9
      2'b01: nxt_st.blink = `PCRB_BLINK_32;
      2'b10: nxt_st.blink = `PCRB_BLINK_64;
      default: nxt_st.blink = `PCRB_BLINK_128;
    endcase
    // Maximum contrast, suppressed by gray conversion.
    nxt_st.fg = fg_gray_i;
    nxt_st.bg = bg_gray_i;
    if (text_mode_i && r_en[`PCRB_EN_MAXCON] && !r_if[`PCRB_IF_GRAY] && (fg_gray_i > bg_gray_i))
    begin
      nxt_st.fg = `PCRB_GRAY_MAX; // RULE10
      nxt_st.bg = `PCRB_GRAY_MIN; // RULE10
    end
    // Gray straight from RGBI, bypassing the palette.
    nxt_st.emu_en = (text_mode_i && r_en[`PCRB_EN_ATTR]) || (gfx16_i && r_en[`PCRB_EN_RGBI]); // RULE11
    nxt_st.emu = attr_rgbi_i; // RULE11
    // Panel sync selection.
    nxt_st.lp = r_if[`PCRB_IF_CRTLIKE] ? hsync_i : line_pulse_i; // RULE3
    nxt_st.fm = r_if[`PCRB_IF_CRTLIKE] ? vsync_i : frame_marker_i; // RULE3
    if (r_if[`PCRB_IF_TV])
    begin
      nxt_st.hs = r_rs[`PCRB_RS_EQ] ? csync_eq_i : csync_i; // RULE7 RULE21
    end
    else
    begin
      nxt_st.hs = hsync_i;
    end
    // AC modulation phase toggling.
    nxt_st.fm_prev = frame_marker_i;
    if (r_ac == 8'h00)
    begin
      nxt_st.ac_cnt = 8'h00;
      if (frame_marker_i && !st_ff.fm_prev)
      begin
        nxt_st.ac_phase = ~st_ff.ac_phase; // RULE18
      end
    end
    else if (line_pulse_i)
    begin
      if (st_ff.ac_cnt + 8'h01 >= r_ac)
      begin
        nxt_st.ac_cnt = 8'h00;
        nxt_st.ac_phase = ~st_ff.ac_phase; // RULE18
      end
      else
      begin
        nxt_st.ac_cnt = st_ff.ac_cnt + 8'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Registered outputs.
  assign rvalid_o = st_ff.rvalid;
  assign pix_o = st_ff.pix;
  assign fg_gray_o = st_ff.fg;
  assign bg_gray_o = st_ff.bg;
  assign emu_gray_o = st_ff.emu;
  assign emu_gray_en_o = st_ff.emu_en;
  assign blink_mask_o = st_ff.blink;
  assign line_pulse_o = st_ff.lp;
  assign frame_marker_o = st_ff.fm;
  assign hsync_o = st_ff.hs;
  assign ac_modulation_output_o = st_ff.ac_phase;
endmodule : pcrb_bank

// ==== pcrb_bank_props.sv ====
// Port-level checks of the panel control register bank.
`timescale 1ns/1ns
module pcrb_bank_props
  import pcrb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pcrb_pkg::pcrb_io_t io_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire pcrb_pkg::pcrb_ptype_t ptype_i,
  input wire logic text_mode_i,
  input wire logic ext_vtim_i,
  input wire logic [1:0] misc_out_hi_i,
  input wire logic [7:0] pix_i,
  input wire pcrb_pkg::pcrb_mode_t mode_o,
  input wire logic [7:0] pix_o,
  input wire logic [7:0] blink_mask_o,
  input wire logic vexp_o,
  input wire logic hexp_o,
  input wire logic use_600_grp_o,
  input wire logic gfx16_i,
  input wire logic [3:0] attr_rgbi_i,
  input wire logic [3:0] fg_gray_i,
  input wire logic [3:0] bg_gray_i,
  input wire logic line_pulse_i,
  input wire logic frame_marker_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic csync_i,
  input wire logic csync_eq_i,
  input wire logic [3:0] fg_gray_o,
  input wire logic [3:0] bg_gray_o,
  input wire logic [3:0] emu_gray_o,
  input wire logic emu_gray_en_o,
  input wire logic line_pulse_o,
  input wire logic frame_marker_o,
  input wire logic hsync_o
);
  logic [7:0] gray_exp_ff;
  logic [4:0] emu_exp_ff;
  logic [2:0] sync_exp_ff;
  logic [7:0] idx_ff;
  logic [7:0] sh_ff [7];
  logic [7:0] exp_ff;
  logic hit;
  logic rd_hit;
  logic [2:0] slot;
  assign hit = idx_ff >= 8'ha1 && idx_ff <= 8'ha7;
  assign slot = 3'(idx_ff - 8'ha1);
  assign rd_hit = io_i.rd && io_i.addr == 16'h03d5;
  // Mirrors index and data writes so outputs can be tied to the bytes behind them.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx_ff <= 8'h00;
      exp_ff <= 8'h00;
      gray_exp_ff <= 8'h00;
      emu_exp_ff <= 5'h00;
      sync_exp_ff <= 3'h0;
      for (int i = 0; i < 7; i++)
        sh_ff[i] <= 8'h00;
    end
    else
    begin
      if (io_i.wr && io_i.addr == 16'h03d4)
        idx_ff <= io_i.wdata;
      if (io_i.wr && io_i.addr == 16'h03d5 && hit)
        sh_ff[slot] <= io_i.wdata;
      exp_ff <= hit ? sh_ff[slot] : 8'h00;
      // Expected registered panel outputs, one cycle after their inputs.
      gray_exp_ff <= (text_mode_i && sh_ff[1][4] && !sh_ff[0][6] && fg_gray_i > bg_gray_i) ?
        8'hf0 : {fg_gray_i, bg_gray_i};
      emu_exp_ff <= {(text_mode_i && sh_ff[1][5]) || (gfx16_i && sh_ff[1][6]), attr_rgbi_i};
      sync_exp_ff <= {sh_ff[0][7] ? (sh_ff[4][4] ? csync_eq_i : csync_i) : hsync_i,
        sh_ff[0][2] ? hsync_i : line_pulse_i, sh_ff[0][2] ? vsync_i : frame_marker_i};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RD_ANSWER: assert property (rd_hit |=> rvalid_o && rdata_o == exp_ff)
    else $error("read answer wrong");
  AST_RD_QUIET: assert property (!rd_hit |=> !rvalid_o)
    else $error("read valid without request");
  AST_IFSEL: assert property ({mode_o.tv_en, mode_o.gray_conv, mode_o.plasma8, mode_o.fp_en,
    mode_o.crt_en, mode_o.crt_like_sync, mode_o.enh_stn, mode_o.stn8} == (sh_ff[0] ^ 8'h08))
    else $error("interface decode wrong");
  AST_BLINK: assert property (1'b1 |=> blink_mask_o == (8'h10 << $past(sh_ff[1][3:2])) - 8'h01)
    else $error("blink mask wrong");
  AST_PIX: assert property (1'b1 |=> pix_o == ($past(pix_i) ^
    {8{$past(text_mode_i) ? $past(sh_ff[1][0]) : $past(sh_ff[1][1])}}))
    else $error("pixel inversion wrong");
  AST_EXPAND: assert property (vexp_o == (text_mode_i ? sh_ff[2][0] : sh_ff[2][1]) &&
    hexp_o == (text_mode_i ? sh_ff[4][2] : sh_ff[4][3]))
    else $error("expansion wrong");
  AST_GRP600: assert property (use_600_grp_o == (ext_vtim_i && misc_out_hi_i == 2'b11 && sh_ff[4][1]))
    else $error("group select wrong");
  AST_SHADOW: assert property (mode_o.shadow_mono == (sh_ff[2][3] && ptype_i == PCRB_PT_MONO_DS) &&
    mode_o.ext_fb == (sh_ff[2][5] && ptype_i == PCRB_PT_COLOR_DS))
    else $error("frame buffer gating wrong");
  AST_WIDTH: assert property (mode_o.panel_800 == sh_ff[4][0])
    else $error("panel width wrong");
  AST_GRAY: assert property ({fg_gray_o, bg_gray_o} == gray_exp_ff)
    else $error("contrast gray wrong");
  AST_EMU: assert property ({emu_gray_en_o, emu_gray_o} == emu_exp_ff)
    else $error("emulated gray wrong");
  AST_SYNC: assert property ({hsync_o, line_pulse_o, frame_marker_o} == sync_exp_ff)
    else $error("sync selection wrong");
  AST_MISC: assert property (mode_o.full_cursor == (sh_ff[1][7] && text_mode_i) &&
    mode_o.dot8 == sh_ff[2][2] && mode_o.tv_eq == sh_ff[4][4] &&
    mode_o.extra_lines == ({1'b0, sh_ff[2][6]} + {1'b0, sh_ff[2][7]}))
    else $error("misc mode decode wrong");
endmodule : pcrb_bank_props
bind pcrb_bank pcrb_bank_props props_u (.clk_i, .rst_i, .io_i, .rdata_o, .rvalid_o, .ptype_i,
  .text_mode_i, .ext_vtim_i, .misc_out_hi_i, .pix_i, .mode_o, .pix_o, .blink_mask_o, .vexp_o,
  .hexp_o, .use_600_grp_o, .gfx16_i, .attr_rgbi_i, .fg_gray_i, .bg_gray_i, .line_pulse_i,
  .frame_marker_i, .hsync_i, .vsync_i, .csync_i, .csync_eq_i, .fg_gray_o, .bg_gray_o, .emu_gray_o,
  .emu_gray_en_o, .line_pulse_o, .frame_marker_o, .hsync_o);

// ==== pcrb_panel_model.sv ====
// Flat panel timing partner giving line and frame strobes.
`timescale 1ns/1ns
module pcrb_panel_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic line_pulse_o,
  output logic frame_marker_o
);
  logic [5:0] pos_ff;
  // A line lasts eight clocks and a frame eight lines.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pos_ff <= 6'h00;
    else
      pos_ff <= pos_ff + 6'h01;
  end
  assign line_pulse_o = pos_ff[2:0] == 3'h7;
  assign frame_marker_o = pos_ff == 6'h3f;
endmodule : pcrb_panel_model

// ==== tb_pcrb_bank.sv ====
// Self-checking bench for the panel control register bank.
`timescale 1ns/1ns
module tb_pcrb_bank;
  import pcrb_pkg::*;
  localparam logic [7:0] ROWS [9][3] = '{'{8'ha1, 8'h5a, 8'h5a}, '{8'ha2, 8'hc3, 8'hc3},
    '{8'ha3, 8'hff, 8'hff}, '{8'ha4, 8'h81, 8'h81}, '{8'ha5, 8'h1f, 8'h1f},
    '{8'ha6, 8'ha5, 8'ha5}, '{8'ha7, 8'h3c, 8'h3c}, '{8'ha8, 8'h77, 8'h00}, '{8'ha0, 8'h11, 8'h00}};
  localparam pcrb_ptype_t PT [3] = '{PCRB_PT_MONO_DS, PCRB_PT_COLOR_DS, PCRB_PT_OTHER};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  pcrb_io_t io_i = '0;
  pcrb_ptype_t ptype_i = PCRB_PT_OTHER;
  logic text_mode_i = 1'b0;
  logic ext_vtim_i = 1'b0;
  logic [1:0] misc_out_hi_i = 2'b00;
  logic [7:0] cnt = 8'h00;
  logic line_pulse_i;
  logic frame_marker_i;
  logic [7:0] rdata_o;
  logic rvalid_o;
  pcrb_mode_t mode_o;
  logic [7:0] blink_mask_o;
  logic vexp_o;
  logic hexp_o;
  logic use_600_grp_o;
  logic ac_modulation_output_o;
  int fails = 0;
  int samples_checked = 0;
  // The counter feeds every data input and the hsync, vsync and csync inputs; the panel model drives the line and frame strobes.
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cnt <= #1 cnt + 8'h01;
  pcrb_panel_model panel_u (.clk_i, .rst_i, .line_pulse_o(line_pulse_i),
    .frame_marker_o(frame_marker_i));
  pcrb_bank dut_u (.clk_i, .rst_i, .io_i, .rdata_o, .rvalid_o, .ptype_i, .text_mode_i,
    .gfx16_i(cnt[5]), .ext_vtim_i, .misc_out_hi_i, .pix_i(cnt), .attr_rgbi_i(cnt[5:2]),
    .fg_gray_i(cnt[3:0]), .bg_gray_i(cnt[7:4]), .line_pulse_i, .frame_marker_i,
    .hsync_i(cnt[2]), .vsync_i(cnt[6]), .csync_i(cnt[3]), .csync_eq_i(cnt[4]), .mode_o,
    .pix_o(), .fg_gray_o(), .bg_gray_o(), .emu_gray_o(), .emu_gray_en_o(), .blink_mask_o,
    .vexp_o, .hexp_o, .use_600_grp_o, .line_pulse_o(), .frame_marker_o(), .hsync_o(),
    .ac_modulation_output_o);
  task summarize;
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  // One port cycle held for a whole clock; the read answer is visible on return.
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    io_i = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
    io_i = '0;
  endtask : bus
  task wreg(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, 16'h03d4, idx);
    bus(1'b1, 16'h03d5, d);
  endtask : wreg
  task rchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b1, 16'h03d4, idx);
    bus(1'b0, 16'h03d5, 8'h00);
    chk8({7'h00, rvalid_o}, 8'h01);
    chk8(rdata_o, exp);
  endtask : rchk
  // Counts strobes between two phase changes of the modulation output.
  task ac_gap(input logic [7:0] exp, input logic use_fm);
    logic [7:0] n;
    logic last;
    int ph;
    n = 8'h00;
    ph = 0;
    last = ac_modulation_output_o;
    for (int k = 0; k < 2000 && ph < 2; k++)
    begin
      @(posedge clk_i);
      #1;
      if (ac_modulation_output_o !== last)
        ph++;
      if (ph == 1 && (use_fm ? frame_marker_i : line_pulse_i))
        n++;
      last = ac_modulation_output_o;
    end
    if (ph < 2)
    begin
      fails++;
      summarize();
    end
    else
    begin
      chk8(n, exp);
    end
  endtask : ac_gap
  initial
  begin
    logic [7:0] v;
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      wreg(ROWS[i][0], ROWS[i][1]);
      rchk(ROWS[i][0], ROWS[i][2]);
    end
    // A reset in mid-run must clear every byte the table left behind.
    @(posedge clk_i);
    #1;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 7; i++)
      rchk(8'ha1 + 8'(i), 8'h00);
    chk8({7'h00, mode_o.crt_en}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      wreg(8'ha1, 8'h01 << i);
      v = {mode_o.tv_en, mode_o.gray_conv, mode_o.plasma8, mode_o.fp_en, mode_o.crt_en,
        mode_o.crt_like_sync, mode_o.enh_stn, mode_o.stn8};
      chk8(v, (8'h01 << i) ^ 8'h08);
    end
    for (int s = 0; s < 4; s++)
    begin
      wreg(8'ha2, 8'(s << 2));
      @(posedge clk_i);
      #1;
      chk8(blink_mask_o, (8'h10 << s) - 8'h01);
    end
    wreg(8'ha3, 8'h38);
    for (int p = 0; p < 3; p++)
    begin
      @(posedge clk_i);
      #1;
      ptype_i = PT[p];
      #1;
      chk8({6'h00, mode_o.shadow_mono, mode_o.ext_fb}, {6'h00, p == 0, p == 1});
    end
    wreg(8'ha2, 8'h01);
    wreg(8'ha5, 8'h03);
    wreg(8'ha3, 8'h01);
    ext_vtim_i = 1'b1;
    misc_out_hi_i = 2'b11;
    text_mode_i = 1'b1;
    #1;
    chk8({5'h00, use_600_grp_o, vexp_o, mode_o.panel_800}, 8'h07);
    @(posedge clk_i);
    #1;
    misc_out_hi_i = 2'b10;
    text_mode_i = 1'b0;
    #1;
    chk8({6'h00, use_600_grp_o, vexp_o}, 8'h00);
    // Text mode with contrast, emulation, cursor, TV sync and extra line bits all set.
    @(posedge clk_i);
    #1;
    text_mode_i = 1'b1;
    wreg(8'ha1, 8'h84);
    wreg(8'ha5, 8'h14);
    wreg(8'ha2, 8'hb0);
    wreg(8'ha3, 8'hc4);
    chk8({3'h0, mode_o.dot8, hexp_o, mode_o.full_cursor, mode_o.extra_lines}, 8'h1e);
    repeat (64) @(posedge clk_i);
    #1;
    wreg(8'ha5, 8'h04);
    repeat (32) @(posedge clk_i);
    #1;
    wreg(8'ha4, 8'h03);
    ac_gap(8'h03, 1'b0);
    wreg(8'ha4, 8'h00);
    ac_gap(8'h01, 1'b1);
    summarize();
  end
endmodule : tb_pcrb_bank
